// ### hw/uig_top.sv
// User interrupt generator: AXI4-Lite registers, memory, interrupt sequencer
`timescale 1ns/10ps
`include "uig_consts.svh"
module uig_top #(
  parameter int NUM_IRQ = 16,
  parameter int MEM_DEPTH = 1024,
  parameter int AXI_AW = 32
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // AXI4-Lite write address and data
  input wire logic [AXI_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [AXI_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // User interrupt handshake toward the DMA subsystem
  output logic [NUM_IRQ-1:0] o_usr_irq_req,
  input wire logic [NUM_IRQ-1:0] i_usr_irq_ack
);
  localparam int MAW = $clog2(MEM_DEPTH);

  // Memory port bundle and instance
  uig_mem_if #(.AW(MAW)) mem_bus ();
  uig_bram #(.DEPTH(MEM_DEPTH), .AW(MAW)) u_bram (
    .i_clk_sys(i_clk_sys),
    .mem(mem_bus.ctrl)
  );

  // Bus state
  logic rd_pend; // Read accepted, memory data arrives next cycle
  logic [12:0] rd_addr; // Latched read address
  logic [31:0] scratch; // Scratch pad contents
  logic [NUM_IRQ-1:0] trig; // Interrupt trigger bits
  logic [NUM_IRQ-1:0] ready; // Ready flags, one per interrupt

  // Handshake decode
  wire wr_fire = i_awvalid && o_awready;
  wire rd_fire = i_arvalid && o_arready;
  // Both channels are taken together so no address or data skid is needed
  wire next_wr_acc = i_awvalid && i_wvalid && !o_awready && !o_bvalid;
  // Write wins the single memory port when both arrive together
  wire next_rd_acc = i_arvalid && !o_arready && !o_rvalid && !rd_pend &&
                     !next_wr_acc;

  // Address decode
  wire [12:0] wa = i_awaddr[12:0];
  wire [12:0] ra = i_araddr[12:0];
  wire wa_mem = (wa >= `UIG_MEM_BASE) && (wa < `UIG_MEM_END);
  wire ra_mem = (ra >= `UIG_MEM_BASE) && (ra < `UIG_MEM_END);
  wire [12:0] wa_off = wa - `UIG_MEM_BASE;
  wire [12:0] ra_off = ra - `UIG_MEM_BASE;
  wire wr_scratch = wr_fire && (wa == `UIG_OFS_SCRATCH);
  wire wr_trig = wr_fire && (wa == `UIG_OFS_TRIG);
  wire [31:0] wmask = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}},
                       {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};

  // Memory port selection
  assign mem_bus.en = (wr_fire && wa_mem) || (rd_fire && ra_mem);
  assign mem_bus.we = (wr_fire && wa_mem) ? i_wstrb : 4'h0;
  assign mem_bus.addr = wr_fire ? wa_off[MAW+1:2] : ra_off[MAW+1:2];
  assign mem_bus.wdata = i_wdata;

  // Size descriptor: fixed 4 KB
  wire [31:0] mem_size = {24'h00_0000, `UIG_SIZE_EXP,
                          uig_pkg::UIG_UNIT_KB};

  // Read data selection, unmapped offsets give zero
  wire rsel_mem = (rd_addr >= `UIG_MEM_BASE) && (rd_addr < `UIG_MEM_END);
  wire [31:0] trig_w = 32'(trig);
  wire [31:0] ready_w = 32'(ready);
  wire [31:0] next_rdata =
    rsel_mem ? mem_bus.rdata :
    (rd_addr == `UIG_OFS_SCRATCH) ? scratch :
    (rd_addr == `UIG_OFS_MEMSIZE) ? mem_size :
    (rd_addr == `UIG_OFS_TRIG) ? trig_w :
    (rd_addr == `UIG_OFS_READY) ? ready_w : 32'h0000_0000;

  // Write channel: one-cycle ready pulse, response held until taken
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
    end else begin
      o_awready <= next_wr_acc;
      o_wready <= next_wr_acc;
      // Set on acceptance, clear when the master takes it
      if (wr_fire) begin
        o_bvalid <= 1'b1;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Every access answers OKAY, including unmapped ones
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_bresp <= `UIG_RESP_OKAY;
      o_rresp <= `UIG_RESP_OKAY;
    end else begin
      o_bresp <= `UIG_RESP_OKAY;
      o_rresp <= `UIG_RESP_OKAY;
    end
  end

  // Read channel: accept, wait for memory, then present data
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_arready <= 1'b0;
      rd_pend <= 1'b0;
      rd_addr <= 13'h0000;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else begin
      o_arready <= next_rd_acc;
      rd_pend <= rd_fire;
      if (rd_fire) begin
        rd_addr <= ra;
      end
      // Data is loaded once; rvalid holds until the master accepts
      if (rd_pend) begin
        o_rvalid <= 1'b1;
        o_rdata <= next_rdata;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Scratch pad and trigger register, byte strobes honoured
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      scratch <= `UIG_SCRATCH_RST;
      trig <= NUM_IRQ'(`UIG_TRIG_RST);
    end else begin
      if (wr_scratch) begin
        scratch <= (scratch & ~wmask) | (i_wdata & wmask);
      end
      // Plain storage: software alone clears a bit after service
      if (wr_trig) begin
        trig <= (trig & ~wmask[NUM_IRQ-1:0]) |
                (i_wdata[NUM_IRQ-1:0] & wmask[NUM_IRQ-1:0]);
      end
    end
  end

  // One sequencer per interrupt line
  genvar k;
  for (k = 0; k < NUM_IRQ; k++) begin : g_irq
    uig_pkg::uig_irq_st_e st;
    uig_pkg::uig_irq_st_e next_st;

    // Next state: start, wait for ack, hold until trigger cleared
    always_comb begin
      case (st)
        uig_pkg::UIG_IDLE: begin
          // Only a ready line may start a new request
          next_st = trig[k] ? uig_pkg::UIG_REQ : uig_pkg::UIG_IDLE;
        end
        uig_pkg::UIG_REQ: begin
          next_st = i_usr_irq_ack[k] ? uig_pkg::UIG_HELD : uig_pkg::UIG_REQ;
        end
        uig_pkg::UIG_HELD: begin
          // The ack alone does not end it; a cleared source does
          next_st = trig[k] ? uig_pkg::UIG_HELD : uig_pkg::UIG_IDLE;
        end
        default: begin
          next_st = uig_pkg::UIG_IDLE;
        end
      endcase
    end

    // State and request flop move together so flag and request agree
    always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
        st <= uig_pkg::UIG_IDLE;
        o_usr_irq_req[k] <= 1'b0;
      end else begin
        st <= next_st;
        o_usr_irq_req[k] <= (next_st != uig_pkg::UIG_IDLE);
      end
    end

    // Ready reads one only when back in idle
    assign ready[k] = (st == uig_pkg::UIG_IDLE);

    // Checks per interrupt line
    chk_trig_start: assert property (
      @(posedge i_clk_sys) disable iff (!i_nrst)
      ready[k] && trig[k] |=> o_usr_irq_req[k])
      else $error("trigger bit did not raise request");
    chk_ready_gate: assert property (
      @(posedge i_clk_sys) disable iff (!i_nrst)
      $rose(o_usr_irq_req[k]) |-> $past(ready[k]))
      else $error("request raised while line not ready");
    chk_flag_busy: assert property (
      @(posedge i_clk_sys) disable iff (!i_nrst)
      ready[k] == !o_usr_irq_req[k])
      else $error("ready flag disagrees with request");
    chk_hold_after_ack: assert property (
      @(posedge i_clk_sys) disable iff (!i_nrst)
      o_usr_irq_req[k] && i_usr_irq_ack[k] && trig[k]
      |=> o_usr_irq_req[k] [*2] or (o_usr_irq_req[k] ##1 !trig[k]))
      else $error("request dropped after ack while source set");
    chk_drop_clear: assert property (
      @(posedge i_clk_sys) disable iff (!i_nrst)
      st == uig_pkg::UIG_HELD && !trig[k] |=> !o_usr_irq_req[k] && ready[k])
      else $error("request not dropped after source cleared");
  end

  // Bus checks
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  sequence s_rd_answer;
    !o_rvalid ##1 o_rvalid;
  endsequence

  chk_read_latency: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    s_rd_taken |-> ##1 s_rd_answer)
    else $error("read data not presented two cycles after accept");
  chk_size_value: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    rd_pend && rd_addr == `UIG_OFS_MEMSIZE
    |=> o_rvalid && o_rdata[`UIG_SIZE_EXP_HI:`UIG_SIZE_EXP_LO] == 4'h2 &&
        o_rdata[`UIG_SIZE_UNIT_HI:`UIG_SIZE_UNIT_LO] == 4'h1)
    else $error("size descriptor not 4 KB");
  chk_write_resp: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_awvalid && o_awready |-> o_wready ##1 o_bvalid && !o_awready)
    else $error("write accepted without response");
  chk_scratch_rw: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    wr_scratch && i_wstrb == 4'hF |=> scratch == $past(i_wdata))
    else $error("scratch pad did not store write");
  chk_unmapped_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    rd_pend && !rsel_mem && rd_addr[12:4] != 9'h000
    |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");
endmodule

// ### hw/uig_consts.svh
// Address map, reset values and field codes of the user interrupt generator
`ifndef UIG_CONSTS_SVH
`define UIG_CONSTS_SVH
// Register offsets inside the window (13-bit byte address)
`define UIG_OFS_SCRATCH 13'h0000
`define UIG_OFS_MEMSIZE 13'h0004
`define UIG_OFS_TRIG 13'h0008
`define UIG_OFS_READY 13'h000C
// Memory window, end is exclusive
`define UIG_MEM_BASE 13'h0800
`define UIG_MEM_END 13'h1800
// Size descriptor fields: exponent bits [7:4], unit bits [3:0]
`define UIG_SIZE_EXP_HI 7
`define UIG_SIZE_EXP_LO 4
`define UIG_SIZE_UNIT_HI 3
`define UIG_SIZE_UNIT_LO 0
// 2^2 x 1 KB = 4 KB for 1K words of 32 bits
`define UIG_SIZE_EXP 4'h2
// Reset values
`define UIG_SCRATCH_RST 32'h0000_0000
`define UIG_TRIG_RST 32'h0000_0000
// AXI response code
`define UIG_RESP_OKAY 2'h0
`endif

// ### hw/uig_pkg.sv
// Types shared by the user interrupt generator modules
package uig_pkg;
  // Unit codes of the size descriptor low nibble
  typedef enum logic [3:0] {
    UIG_UNIT_BYTE = 4'h0,
    UIG_UNIT_KB = 4'h1,
    UIG_UNIT_MB = 4'h2,
    UIG_UNIT_GB = 4'h3
  } uig_unit_e;
  // Per-interrupt sequence, one-hot
  typedef enum logic [2:0] {
    UIG_IDLE = 3'b001,
    UIG_REQ = 3'b010,
    UIG_HELD = 3'b100
  } uig_irq_st_e;
endpackage

// ### hw/uig_mem_if.sv
// Port bundle between the register front end and the block memory
`timescale 1ns/10ps
interface uig_mem_if #(
  parameter int AW = 10
);
  logic en;
  logic [3:0] we;
  logic [AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output en, we, addr, wdata, input rdata);
  modport mem (input en, we, addr, wdata, output rdata);
endinterface

// ### hw/uig_bram.sv
// Single-port block memory with byte write enables, one-cycle read
`timescale 1ns/10ps
module uig_bram #(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  // Clock
  input wire logic i_clk_sys,
  // Access port
  uig_mem_if.mem mem
);
  // One byte-wide bank per lane, so every bank has a single writer
  genvar b;
  for (b = 0; b < 4; b++) begin : g_lane
    // Bank storage; no reset so it maps onto block RAM
    logic [7:0] bank [DEPTH];

    // Byte write and registered read, old data on a same-address write
    always_ff @(posedge i_clk_sys) begin
      if (mem.en && mem.we[b]) begin
        bank[mem.addr] <= mem.wdata[8*b +: 8];
      end
      if (mem.en) begin
        mem.rdata[8*b +: 8] <= bank[mem.addr];
      end
    end
  end
endmodule

// ### dv/uig_irq_partner.sv
// Model of the DMA subsystem side that acknowledges user interrupts
`timescale 1ns/10ps
module uig_irq_partner #(
  parameter int N = 16
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Ack latency in cycles
  input wire logic [7:0] i_delay,
  // Interrupt handshake
  input wire logic [N-1:0] i_req,
  output logic [N-1:0] o_ack
);
  logic [N-1:0] acked; // Lines already answered
  logic [7:0] cnt; // Cycles the oldest request has waited
  wire logic [N-1:0] pend = i_req & ~acked; // Unanswered requests
  // One ack pulse per request; a dropped line may be requested anew
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_ack <= '0;
      acked <= '0;
      cnt <= 8'h00;
    end else if (pend != '0 && cnt >= i_delay) begin
      o_ack <= pend;
      acked <= (acked & i_req) | pend;
      cnt <= 8'h00;
    end else begin
      o_ack <= '0;
      acked <= acked & i_req;
      cnt <= (pend != '0) ? cnt + 8'h01 : 8'h00;
    end
  end
endmodule

// ### dv/tb_user_irq_generator.sv
// Self-checking bench of the user interrupt generator
`timescale 1ns/10ps
module tb_user_irq_generator;
  // Clock, reset and host bus drives
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1; // Host always accepts
  // Design answers
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] req, ack;
  logic [7:0] delay = 8'h02; // Partner ack latency
  int mismatches = 0, samples_checked = 0, cycles = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  uig_top dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .o_usr_irq_req(req),
    .i_usr_irq_ack(ack));
  uig_irq_partner part_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_delay(delay), .i_req(req), .o_ack(ack));
  // Verdict and counts, the single exit of the run
  task automatic end_sim();
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard: the tests need well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Drives always land 2 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask
  // Write: address and data together, held until the ready edge
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
    awaddr = a;
    wdata = d;
    wstrb = s;
    awvalid = 1'b1;
    wvalid = 1'b1;
    do @(posedge i_clk_sys); while (awready !== 1'b1);
    chk({31'h0000_0000, wready}, 32'h0000_0001);
    #2;
    awvalid = 1'b0;
    wvalid = 1'b0;
    do @(posedge i_clk_sys); while (bvalid !== 1'b1);
    chk({30'h0000_0000, bresp}, 32'h0000_0000);
    #2;
  endtask
  // Read and compare; data taken at the edge that sees rvalid
  task automatic rd(input logic [31:0] a, exp);
    araddr = a;
    arvalid = 1'b1;
    do @(posedge i_clk_sys); while (arready !== 1'b1);
    #2;
    arvalid = 1'b0;
    do @(posedge i_clk_sys); while (rvalid !== 1'b1);
    chk(rdata, exp);
    chk({30'h0000_0000, rresp}, 32'h0000_0000);
    #2;
  endtask
  task automatic req_is(input logic [15:0] e);
    chk({16'h0000, req}, {16'h0000, e});
  endtask
  task automatic t_reset();
    rd(32'h0000_0000, 32'h0000_0000);
    rd(32'h0000_0004, 32'h0000_0021);
    rd(32'h0000_0008, 32'h0000_0000);
    rd(32'h0000_000C, 32'h0000_FFFF);
    $display("Test reset values done");
  endtask
  // Strobed scratch write, read-only size, unmapped holes
  task automatic t_regs();
    wr(32'h0000_0000, 32'hA5A5_5A5A, 4'hF);
    wr(32'h0000_0000, 32'h1234_5678, 4'h3);
    rd(32'h0000_0000, 32'hA5A5_5678);
    wr(32'h0000_0004, 32'hFFFF_FFFF, 4'hF);
    rd(32'h0000_0004, 32'h0000_0021);
    wr(32'h0000_0008, 32'hFFFF_0000, 4'hF);
    rd(32'h0000_0008, 32'h0000_0000);
    req_is(16'h0000);
    rd(32'h0000_0010, 32'h0000_0000);
    rd(32'h0000_1800, 32'h0000_0000);
    $display("Test registers done");
  endtask
  // First and last memory words, one byte lane alone
  task automatic t_mem();
    wr(32'h0000_0800, 32'hDEAD_0001, 4'hF);
    wr(32'h0000_17FC, 32'h0BAD_F00D, 4'hF);
    wr(32'h0000_0804, 32'h0000_0000, 4'hF);
    wr(32'h0000_0804, 32'hFFFF_FFFF, 4'h4);
    rd(32'h0000_0800, 32'hDEAD_0001);
    rd(32'h0000_17FC, 32'h0BAD_F00D);
    rd(32'h0000_0804, 32'h00FF_0000);
    $display("Test memory done");
  endtask
  // Prompt ack; a repeated write while busy must not restart
  task automatic t_fast();
    wr(32'h0000_0008, 32'h0000_0001, 4'hF);
    tick(2);
    req_is(16'h0001);
    rd(32'h0000_000C, 32'h0000_FFFE);
    wr(32'h0000_0008, 32'h0000_0001, 4'hF);
    tick(10);
    req_is(16'h0001);
    wr(32'h0000_0008, 32'h0000_0000, 4'hF);
    tick(3);
    req_is(16'h0000);
    rd(32'h0000_000C, 32'h0000_FFFF);
    $display("Test prompt interrupt done");
  endtask
  // Slow ack on two lines, cleared one by one after service
  task automatic t_slow();
    delay = 8'h14;
    wr(32'h0000_0008, 32'h0000_8008, 4'hF);
    tick(4);
    req_is(16'h8008);
    rd(32'h0000_000C, 32'h0000_7FF7);
    tick(30);
    req_is(16'h8008);
    wr(32'h0000_0008, 32'h0000_0008, 4'hF);
    tick(3);
    req_is(16'h0008);
    rd(32'h0000_000C, 32'h0000_FFF7);
    wr(32'h0000_0008, 32'h0000_0000, 4'hF);
    tick(3);
    req_is(16'h0000);
    rd(32'h0000_000C, 32'h0000_FFFF);
    // Source cleared before the ack: request waits for the ack first
    wr(32'h0000_0008, 32'h0000_0001, 4'hF);
    tick(2);
    wr(32'h0000_0008, 32'h0000_0000, 4'hF);
    tick(3);
    req_is(16'h0001);
    tick(20);
    req_is(16'h0000);
    rd(32'h0000_000C, 32'h0000_FFFF);
    $display("Test slow interrupt done");
  endtask
  // Reset for 12 cycles, then one more edge after release and the five tests in order
  initial begin
    tick(12);
    i_nrst = 1'b1;
    tick(1);
    t_reset();
    t_regs();
    t_mem();
    t_fast();
    t_slow();
    end_sim();
  end
endmodule
